/* File: common/hpcp_pkg.sv */
// Functional notes
// [R01] Share strap low: separate address; high: shared.
// [R02] Byte lines: data only, or address then data.
// [R03] Host drives low address, or zeros when shared.
// [R04] Separate mode: latch pin is address bit seven.
// [R05] Shared mode: address captured on latch rise.
// [R06] Style strap high: strobe plus direction; low: pair.
// [R07] Read strobe low when shared; strobe high otherwise. Pair style: read strobe low in both modes.
// [R08] Accesses only while chip select is low.
// [R09] Write strobe is active low.
// [R10] Interrupt pulled low while any status bit set.
// [R11] Test pin high floats every device output.
// [R12] Byte lines driven only during selected reads.
// [R13] Write stored at the strobe's trailing edge.
package hpcp_pkg;

    // ------------------------------------------------------------
    // Widths and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LOW_ADDR_W = 7;
    localparam int REG_DEPTH = 256;
    localparam int STAT_NUM = 3;
    localparam logic [7:0] OFS_LINK_STATUS = 8'h01;
    localparam logic [7:0] OFS_STATUS_ONE = 8'h20;
    localparam logic [7:0] OFS_STATUS_TWO = 8'h21;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_ADDR = 8'h00;

    // ------------------------------------------------------------
    // Host access sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HPCP_IDLE = 3'b000,
        HPCP_ADDR = 3'b001,
        HPCP_LATCH = 3'b011,
        HPCP_SETUP = 3'b010,
        HPCP_STB1 = 3'b110,
        HPCP_STB2 = 3'b111,
        HPCP_HOLD = 3'b101,
        HPCP_FIN = 3'b100
    } hpcp_state_e;

endpackage

/* File: common/hpcp_if.sv */
`timescale 1ns/1ps
interface hpcp_if;
    logic addr_data_share_sel; // Strap, high selects shared bus.
    logic bus_style_select; // Strap, high selects strobe plus direction.
    logic test_en; // High floats all device outputs.
    logic cs_n; // Chip select.
    logic rd_n; // Read strobe or data strobe.
    logic wr_n; // Write strobe or read/write direction.
    logic address_strobe; // Top address bit or address strobe.
    logic [hpcp_pkg::LOW_ADDR_W-1:0] low_address_pins; // Low address.
    logic [hpcp_pkg::DATA_W-1:0] host_d_o; // Host drive value.
    logic host_d_oe; // Host drives the byte lines.
    logic [hpcp_pkg::DATA_W-1:0] dev_d_o; // Device drive value.
    logic dev_d_oe; // Device drives the byte lines.
    logic int_oe; // Device pulls the interrupt line low.
    logic [hpcp_pkg::DATA_W-1:0] bus_byte_lines; // Resolved byte lines.
    logic int_n; // Resolved interrupt line with pull-up.

    // A floating bus reads as all ones, as a weak pull-up would give.
    assign bus_byte_lines = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'hFF);
    assign int_n = ~int_oe;

    modport dev (
        input addr_data_share_sel, bus_style_select, test_en, cs_n, rd_n, wr_n,
        input address_strobe, low_address_pins, bus_byte_lines,
        output dev_d_o, dev_d_oe, int_oe
    );
    modport host (
        output addr_data_share_sel, bus_style_select, test_en, cs_n, rd_n, wr_n,
        output address_strobe, low_address_pins, host_d_o, host_d_oe,
        input bus_byte_lines, int_n
    );
endinterface

/* File: hw/hpcp_regfile.sv */
`timescale 1ns/1ps
module hpcp_regfile (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic we, // Write enable pulse.
    input wire logic [hpcp_pkg::ADDR_W-1:0] waddr, // Write address.
    input wire logic [hpcp_pkg::DATA_W-1:0] wdata, // Write data.
    input wire logic [hpcp_pkg::ADDR_W-1:0] raddr_a, // Bus read address.
    output logic [hpcp_pkg::DATA_W-1:0] rdata_a, // Bus read data.
    input wire logic [hpcp_pkg::ADDR_W-1:0] raddr_b, // User read address.
    output logic [hpcp_pkg::DATA_W-1:0] rdata_b // User read data.
);
    logic [hpcp_pkg::DATA_W-1:0] mem_r [hpcp_pkg::REG_DEPTH];

    // Cleared word by word so control state is defined after reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < hpcp_pkg::REG_DEPTH; i++) begin
                mem_r[i] <= hpcp_pkg::RST_REG;
            end
        end else if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    assign rdata_a = mem_r[raddr_a];
    assign rdata_b = mem_r[raddr_b];
endmodule // hpcp_regfile

/* File: hw/hpcp_dev.sv */
`timescale 1ns/1ps
module hpcp_dev (
    input wire logic CLK_SYS, // System clock, 10 MHz.
    input wire logic RSTN, // Synchronous reset, active low.
    hpcp_if.dev BUS, // Parallel control port pins.
    input wire logic [7:0] EVT_STATUS_ONE, // Event pulses, status one.
    input wire logic [7:0] EVT_STATUS_TWO, // Event pulses, status two.
    input wire logic [7:0] EVT_LINK_STATUS, // Event pulses, link status.
    input wire logic [7:0] USER_ADDR, // Register to look at.
    output logic [7:0] USER_RDATA, // Its content.
    output logic REG_WSTB, // One-cycle pulse on each stored write.
    output logic [7:0] REG_WADDR, // Address of the last write.
    output logic [7:0] REG_WDATA // Data of the last write.
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Returns the status slot of an address; slot STAT_NUM means none.
    function automatic logic [1:0] stat_slot(input logic [7:0] a);
        unique case (a)
            hpcp_pkg::OFS_STATUS_ONE: stat_slot = 2'd0;
            hpcp_pkg::OFS_STATUS_TWO: stat_slot = 2'd1;
            hpcp_pkg::OFS_LINK_STATUS: stat_slot = 2'd2;
            default: stat_slot = 2'd3;
        endcase
    endfunction

    logic shared;
    logic motor;
    logic rd_stb;
    logic wr_stb;
    logic rd_act;
    logic wr_act;
    logic [7:0] addr_cur;
    logic ale_q_r;
    logic [7:0] addr_lat_r;
    logic wr_q_r;
    logic [7:0] wbuf_addr_r;
    logic [7:0] wbuf_data_r;
    logic commit;
    logic arr_we;
    logic [7:0] arr_rdata;
    logic [7:0] rdata_r;
    logic [7:0] stat_r [hpcp_pkg::STAT_NUM];
    logic [7:0] stat_nxt [hpcp_pkg::STAT_NUM];
    logic [7:0] evt [hpcp_pkg::STAT_NUM];
    logic [hpcp_pkg::STAT_NUM-1:0] stat_any;
    logic [1:0] rd_slot;
    logic [1:0] wr_slot;
    logic [7:0] user_rd;

    // ------------------------------------------------------------
    // Strobe decoding
    // ------------------------------------------------------------
    assign shared = BUS.addr_data_share_sel; // [R01]
    assign motor = BUS.bus_style_select; // [R06]

    // In strobe-plus-direction style the data strobe sense follows the
    // share strap, and the write pin only carries the direction.
    always_comb begin
        if (motor) begin // [R06]
            rd_stb = (shared ? ~BUS.rd_n : BUS.rd_n) & BUS.wr_n; // [R07]
            wr_stb = (shared ? ~BUS.rd_n : BUS.rd_n) & ~BUS.wr_n; // [R07]
        end else begin
            rd_stb = ~BUS.rd_n; // [R07]
            wr_stb = ~BUS.wr_n; // [R09]
        end
    end

    assign rd_act = rd_stb & ~BUS.cs_n; // [R08]
    assign wr_act = wr_stb & ~BUS.cs_n; // [R08]

    // ------------------------------------------------------------
    // Address path
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            ale_q_r <= 1'b0;
        end else begin
            ale_q_r <= BUS.address_strobe;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            addr_lat_r <= hpcp_pkg::RST_ADDR;
        end else if (shared && BUS.address_strobe && !ale_q_r) begin
            addr_lat_r <= BUS.bus_byte_lines; // [R05] [R02]
        end
    end

    // The low address pins are ignored in shared mode.
    assign addr_cur = shared ? addr_lat_r
                             : {BUS.address_strobe, BUS.low_address_pins}; // [R04] [R03]

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    // Address and data are held from the last active cycle so that a
    // select that rises with the strobe does not spoil the write.
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            wr_q_r <= 1'b0;
        end else begin
            wr_q_r <= wr_act;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            wbuf_addr_r <= hpcp_pkg::RST_ADDR;
            wbuf_data_r <= hpcp_pkg::RST_REG;
        end else if (wr_act) begin
            wbuf_addr_r <= addr_cur;
            wbuf_data_r <= BUS.bus_byte_lines; // [R02]
        end
    end

    assign commit = wr_q_r & ~wr_act; // [R13]
    assign wr_slot = stat_slot(wbuf_addr_r);
    assign arr_we = commit & (wr_slot == 2'd3);

    hpcp_regfile u_regs (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .we(arr_we),
        .waddr(wbuf_addr_r),
        .wdata(wbuf_data_r),
        .raddr_a(addr_cur),
        .rdata_a(arr_rdata),
        .raddr_b(USER_ADDR),
        .rdata_b(user_rd)
    );

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            REG_WSTB <= 1'b0;
            REG_WADDR <= hpcp_pkg::RST_ADDR;
            REG_WDATA <= hpcp_pkg::RST_REG;
        end else begin
            REG_WSTB <= commit;
            if (commit) begin
                REG_WADDR <= wbuf_addr_r;
                REG_WDATA <= wbuf_data_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    assign evt[0] = EVT_STATUS_ONE;
    assign evt[1] = EVT_STATUS_TWO;
    assign evt[2] = EVT_LINK_STATUS;

    // A written one clears a bit; a new event in the same cycle wins.
    for (genvar g = 0; g < hpcp_pkg::STAT_NUM; g++) begin : g_stat
        always_comb begin
            stat_nxt[g] = stat_r[g];
            if (commit && wr_slot == 2'(g)) begin
                stat_nxt[g] = stat_r[g] & ~wbuf_data_r;
            end
            stat_nxt[g] = stat_nxt[g] | evt[g];
        end

        always_ff @(posedge CLK_SYS) begin
            if (!RSTN) begin
                stat_r[g] <= hpcp_pkg::RST_REG;
            end else begin
                stat_r[g] <= stat_nxt[g];
            end
        end

        assign stat_any[g] = |stat_r[g];
    end

    assign BUS.int_oe = (|stat_any) & ~BUS.test_en; // [R10] [R11]

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    assign rd_slot = stat_slot(addr_cur);

    // Registered one cycle behind the address; the host waits a cycle.
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            rdata_r <= hpcp_pkg::RST_REG;
        end else if (rd_slot == 2'd3) begin
            rdata_r <= arr_rdata;
        end else begin
            rdata_r <= stat_r[rd_slot];
        end
    end

    assign BUS.dev_d_o = rdata_r;
    assign BUS.dev_d_oe = rd_act & ~BUS.test_en; // [R12] [R11]

    // ------------------------------------------------------------
    // User look-up
    // ------------------------------------------------------------
    // Registered so the user side sees a clean data output; a look-up
    // therefore answers one clock after its address is presented.
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            USER_RDATA <= hpcp_pkg::RST_REG;
        end else begin
            USER_RDATA <= user_rd;
        end
    end
endmodule // hpcp_dev

/* File: hw/hpcp_host.sv */
`timescale 1ns/1ps
module hpcp_host (
    input wire logic CLK_SYS, // System clock, 10 MHz.
    input wire logic RSTN, // Synchronous reset, active low.
    hpcp_if.host BUS, // Parallel control port pins.
    input wire logic SHARE_SEL, // Share strap level to present.
    input wire logic STYLE_SEL, // Style strap level to present.
    input wire logic TEST_EN, // Test pin level to present.
    input wire logic REQ, // Start an access, taken when idle.
    input wire logic REQ_WR, // High for write.
    input wire logic [7:0] REQ_ADDR, // Register address.
    input wire logic [7:0] REQ_WDATA, // Write data.
    output logic BUSY, // Access in progress.
    output logic DONE, // One-cycle pulse at the end of an access.
    output logic [7:0] RDATA, // Data of the last read.
    output logic IRQ // Device interrupt, active high.
);
    hpcp_pkg::hpcp_state_e state_r;
    hpcp_pkg::hpcp_state_e state_nxt;
    logic wr_r;
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic in_cycle;
    logic stb;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        unique case (state_r)
            hpcp_pkg::HPCP_IDLE: state_nxt = REQ ? hpcp_pkg::HPCP_ADDR : hpcp_pkg::HPCP_IDLE;
            hpcp_pkg::HPCP_ADDR: state_nxt = hpcp_pkg::HPCP_LATCH;
            hpcp_pkg::HPCP_LATCH: state_nxt = hpcp_pkg::HPCP_SETUP;
            hpcp_pkg::HPCP_SETUP: state_nxt = hpcp_pkg::HPCP_STB1;
            hpcp_pkg::HPCP_STB1: state_nxt = hpcp_pkg::HPCP_STB2;
            hpcp_pkg::HPCP_STB2: state_nxt = hpcp_pkg::HPCP_HOLD;
            hpcp_pkg::HPCP_HOLD: state_nxt = hpcp_pkg::HPCP_FIN;
            hpcp_pkg::HPCP_FIN: state_nxt = hpcp_pkg::HPCP_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            state_r <= hpcp_pkg::HPCP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            wr_r <= 1'b0;
            addr_r <= hpcp_pkg::RST_ADDR;
            wdata_r <= hpcp_pkg::RST_REG;
        end else if (state_r == hpcp_pkg::HPCP_IDLE && REQ) begin
            wr_r <= REQ_WR;
            addr_r <= REQ_ADDR;
            wdata_r <= REQ_WDATA;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            RDATA <= hpcp_pkg::RST_REG;
        end else if (state_r == hpcp_pkg::HPCP_STB2 && !wr_r) begin
            RDATA <= BUS.bus_byte_lines;
        end
    end

    assign BUSY = (state_r != hpcp_pkg::HPCP_IDLE);
    assign DONE = (state_r == hpcp_pkg::HPCP_FIN);
    assign IRQ = ~BUS.int_n; // [R10]

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    assign in_cycle = (state_r == hpcp_pkg::HPCP_SETUP) || (state_r == hpcp_pkg::HPCP_STB1)
                   || (state_r == hpcp_pkg::HPCP_STB2) || (state_r == hpcp_pkg::HPCP_HOLD);
    assign stb = (state_r == hpcp_pkg::HPCP_STB1) || (state_r == hpcp_pkg::HPCP_STB2);

    assign BUS.addr_data_share_sel = SHARE_SEL; // [R01]
    assign BUS.bus_style_select = STYLE_SEL; // [R06]
    assign BUS.test_en = TEST_EN; // [R11]
    assign BUS.cs_n = ~in_cycle; // [R08]

    always_comb begin
        if (STYLE_SEL) begin // [R06]
            BUS.rd_n = SHARE_SEL ? ~stb : stb; // [R07]
            BUS.wr_n = ~(in_cycle & wr_r);
        end else begin
            BUS.rd_n = ~(stb & ~wr_r); // [R07]
            BUS.wr_n = ~(stb & wr_r); // [R09]
        end
    end

    // Shared mode pulses the latch strobe; separate mode holds bit seven.
    assign BUS.address_strobe = SHARE_SEL ? (state_r == hpcp_pkg::HPCP_LATCH) : addr_r[7]; // [R05] [R04]
    assign BUS.low_address_pins = SHARE_SEL ? 7'h00 : addr_r[6:0]; // [R03]

    always_comb begin
        BUS.host_d_oe = 1'b0;
        BUS.host_d_o = wdata_r;
        if (SHARE_SEL && (state_r == hpcp_pkg::HPCP_ADDR || state_r == hpcp_pkg::HPCP_LATCH)) begin
            BUS.host_d_oe = 1'b1; // [R02]
            BUS.host_d_o = addr_r;
        end else if (wr_r && in_cycle) begin
            BUS.host_d_oe = 1'b1;
        end
    end
endmodule // hpcp_host

/* File: tb/hpcp_properties.sv */
`timescale 1ns/1ps
module hpcp_properties (
    input wire logic CLK_SYS, // System clock.
    input wire logic RSTN, // Synchronous reset, active low.
    input wire logic addr_data_share_sel, // Share strap.
    input wire logic bus_style_select, // Style strap.
    input wire logic test_en, // Test pin.
    input wire logic cs_n, // Chip select.
    input wire logic rd_n, // Read or data strobe.
    input wire logic wr_n, // Write strobe or direction.
    input wire logic address_strobe, // Bit seven or latch strobe.
    input wire logic [hpcp_pkg::LOW_ADDR_W-1:0] low_address_pins, // Low address.
    input wire logic host_d_oe, // Host drives the bytes.
    input wire logic dev_d_oe, // Device drives the bytes.
    input wire logic int_oe // Device pulls the interrupt.
);
    // ----------------
    // Decoded strobes
    // ----------------
    // The data strobe flips sense with the share strap only in direction style.
    logic stb_on;
    logic rd_act;
    logic wr_act;
    logic [2:0] wr_age_r;
    assign stb_on = addr_data_share_sel ? !rd_n : rd_n;
    assign rd_act = bus_style_select ? (wr_n && stb_on) : !rd_n;
    assign wr_act = bus_style_select ? (!wr_n && stb_on) : !wr_n;
    // Cycles since the last selected write, saturating so it never wraps.
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN || (!cs_n && wr_act)) begin
            wr_age_r <= 3'h0;
        end else if (wr_age_r != 3'h7) begin
            wr_age_r <= wr_age_r + 3'h1;
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence s_bus_held;
        host_d_oe && $past(host_d_oe);
    endsequence
    sequence s_select_next;
        ##1 !cs_n;
    endsequence
    a_float_in_test: assert property (test_en |-> !dev_d_oe && !int_oe)
        else $error("device drives a pin in test mode");
    a_drive_only_selected: assert property (dev_d_oe |-> !cs_n)
        else $error("byte lines driven while not selected");
    a_drive_only_read: assert property (dev_d_oe |-> rd_act)
        else $error("byte lines driven outside a read strobe");
    a_drive_when_read: assert property (!cs_n && rd_act && !test_en |-> dev_d_oe)
        else $error("selected read not answered");
    a_no_bus_fight: assert property (!(dev_d_oe && host_d_oe))
        else $error("both ends drive the byte lines");
    a_write_data_driven: assert property (!cs_n && wr_act |-> host_d_oe && !dev_d_oe)
        else $error("write strobe without host data");
    a_low_addr_zero: assert property (addr_data_share_sel && !cs_n |-> low_address_pins == '0)
        else $error("low address pins not low in shared mode");
    a_latch_then_select: assert property (
        addr_data_share_sel && $rose(address_strobe) |-> s_bus_held ##0 s_select_next)
        else $error("address latch not followed by select");
    a_strobe_after_select: assert property ($fell(cs_n) |-> !rd_act && !wr_act)
        else $error("strobe active as select falls");
    a_int_fall_write: assert property ($fell(int_oe) && !test_en |-> wr_age_r <= 3'h5)
        else $error("interrupt released without a write");
endmodule // hpcp_properties

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic rstn;
    logic share_sel, style_sel, test_pin, req, req_wr, busy, done, irq, reg_wstb;
    logic [7:0] req_addr, req_wdata, rdata, evt_one, evt_two, evt_link;
    logic [7:0] user_addr, user_rdata, reg_waddr, reg_wdata;
    int miscompares;
    int checks_done;
    hpcp_if bus ();
    hpcp_dev u_hpcp_dev (.CLK_SYS(clk), .RSTN(rstn), .BUS(bus), .EVT_STATUS_ONE(evt_one),
        .EVT_STATUS_TWO(evt_two), .EVT_LINK_STATUS(evt_link), .USER_ADDR(user_addr),
        .USER_RDATA(user_rdata), .REG_WSTB(reg_wstb), .REG_WADDR(reg_waddr),
        .REG_WDATA(reg_wdata));
    hpcp_host u_hpcp_host (.CLK_SYS(clk), .RSTN(rstn), .BUS(bus), .SHARE_SEL(share_sel),
        .STYLE_SEL(style_sel), .TEST_EN(test_pin), .REQ(req), .REQ_WR(req_wr),
        .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .BUSY(busy), .DONE(done),
        .RDATA(rdata), .IRQ(irq));
    hpcp_properties u_hpcp_properties (.CLK_SYS(clk), .RSTN(rstn),
        .addr_data_share_sel(bus.addr_data_share_sel), .bus_style_select(bus.bus_style_select),
        .test_en(bus.test_en), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .address_strobe(bus.address_strobe), .low_address_pins(bus.low_address_pins),
        .host_d_oe(bus.host_d_oe), .dev_d_oe(bus.dev_d_oe), .int_oe(bus.int_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------
    // Shared tasks
    // ----------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The stored write already shows on REG_WSTB at DONE; two spare edges then let the sequencer return to idle.
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        req_wr <= wr;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            report_and_stop();
        end
        check("wr_stb", {7'h00, reg_wstb}, {7'h00, wr});
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic peek(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        user_addr <= a;
        @(posedge clk);
        #1;
        check("user_rdata", user_rdata, exp);
    endtask

    task automatic pulse_evt(input int i, input logic [7:0] b);
        @(posedge clk);
        evt_one <= (i == 0) ? b : 8'h00;
        evt_two <= (i == 1) ? b : 8'h00;
        evt_link <= (i == 2) ? b : 8'h00;
        @(posedge clk);
        evt_one <= 8'h00;
        evt_two <= 8'h00;
        evt_link <= 8'h00;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_modes();
        logic [7:0] a;
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            share_sel <= m[1];
            style_sel <= m[0];
            a = 8'h95 ^ 8'(m << 3);
            access(1'b1, a, 8'hA0 + 8'(m));
            check("wr_addr", reg_waddr, a);
            check("wr_data", reg_wdata, 8'hA0 + 8'(m));
            access(1'b1, a ^ 8'h80, 8'h50 + 8'(m));
            peek(a, 8'hA0 + 8'(m));
            peek(a ^ 8'h80, 8'h50 + 8'(m));
            access(1'b0, a, 8'h00);
            check("rd_data", rdata, 8'hA0 + 8'(m));
        end
    endtask

    task automatic t_irq();
        logic [7:0] ofs [3];
        ofs = '{hpcp_pkg::OFS_STATUS_ONE, hpcp_pkg::OFS_STATUS_TWO, hpcp_pkg::OFS_LINK_STATUS};
        for (int i = 0; i < 3; i++) begin
            pulse_evt(i, 8'h24);
            check("irq_set", {7'h00, irq}, 8'h01);
            access(1'b0, ofs[i], 8'h00);
            check("status", rdata, 8'h24);
            access(1'b1, ofs[i], 8'h04);
            check("irq_part", {7'h00, irq}, 8'h01);
            access(1'b1, ofs[i], 8'h20);
            check("irq_clr", {7'h00, irq}, 8'h00);
        end
    endtask

    task automatic t_test();
        @(posedge clk);
        test_pin <= 1'b1;
        pulse_evt(1, 8'h01);
        check("irq_float", {7'h00, irq}, 8'h00);
        access(1'b0, 8'h85, 8'h00);
        check("rd_float", rdata, 8'hFF);
        access(1'b1, 8'h33, 8'h6B);
        peek(8'h33, 8'h6B);
        @(posedge clk);
        test_pin <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("irq_back", {7'h00, irq}, 8'h01);
        access(1'b1, hpcp_pkg::OFS_STATUS_TWO, 8'h01);
        check("irq_off", {7'h00, irq}, 8'h00);
    endtask

    initial begin
        miscompares = 0;
        checks_done = 0;
        rstn = 1'b0;
        share_sel = 1'b0;
        style_sel = 1'b0;
        test_pin = 1'b0;
        req = 1'b0;
        req_wr = 1'b0;
        req_addr = 8'h00;
        req_wdata = 8'h00;
        evt_one = 8'h00;
        evt_two = 8'h00;
        evt_link = 8'h00;
        user_addr = 8'h00;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check("busy", {7'h00, busy}, 8'h00);
        check("irq_rst", {7'h00, irq}, 8'h00);
        peek(8'h5A, hpcp_pkg::RST_REG);
        t_modes();
        t_irq();
        t_test();
        report_and_stop();
    end
endmodule // tb_top
